// ===== hw/rbm_pkg.sv
// package: register map, rates and frame carriers of the ring beacon monitor
package rbm_pkg;

  // ----------------------------------------------------------------
  // register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h6c;
  localparam logic [7:0] IDX_STATE = 8'h6e;
  localparam logic [7:0] IDX_TMO_LO = 8'h70;
  localparam logic [7:0] IDX_TMO_HI = 8'h72;
  localparam logic [7:0] IDX_P1_TS_LO = 8'h74;
  localparam logic [7:0] IDX_P1_TS_HI = 8'h76;
  localparam logic [7:0] IDX_P2_TS_LO = 8'h78;
  localparam logic [7:0] IDX_P2_TS_HI = 8'h7a;
  localparam logic [7:0] IDX_NB_W0 = 8'h7c;
  localparam logic [7:0] IDX_NB_W1 = 8'h7e;
  localparam logic [7:0] IDX_NB_W2 = 8'h80;
  localparam logic [7:0] IDX_EVT = 8'h40;
  localparam logic [7:0] IDX_MASK = 8'h42;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_P1_EN_BIT = 7;
  localparam int CTL_P2_EN_BIT = 8;
  localparam int CTL_CLR_BIT = 12;
  localparam int EVT_CHG_BIT = 0;
  localparam int EVT_TMO_BIT = 2;
  localparam int EVT_W = 4;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // rates; counters advance in quarter ticks of the 100 and 50 mhz clocks, added once per system clock
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 40_000_000;
  localparam longint TMO_HZ = 50_000_000;
  localparam longint FRT_HZ = 100_000_000;
  localparam longint QTR = 4;
  localparam logic [3:0] FRT_STEP_Q = 4'(FRT_HZ * QTR / CLK_HZ);
  localparam logic [3:0] TMO_STEP_Q = 4'(TMO_HZ * QTR / CLK_HZ);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic crc_err;
    logic [47:0] src;
    logic [7:0] state;
  } rbm_beacon_s;

  typedef struct packed {
    logic valid;
    logic [47:0] src;
  } rbm_frame_s;

endpackage

// ===== hw/rbm_ring_beacon_monitor.sv
// module: ring beacon monitor with axi4-lite register slave
`timescale 1ns/1ps

module rbm_ring_beacon_monitor
  import rbm_pkg::*;
#(
  parameter int AW = 12
)(
  input wire logic sys_clk_in, // 40 mhz clock
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic [AW-1:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [31:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [AW-1:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [31:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in, // read data ready
  input rbm_beacon_s beacon_in [0:1], // received beacons, index 0 is port 1
  input rbm_frame_s neighbor_frame_in, // port 1 neighbor-check/sign-on frame
  input wire logic [47:0] supervisor_mac_in, // programmed supervisor address
  output logic irq_out // unmasked event pending
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
    reg_idx = 8'(a[9:2]);
  endfunction

  function automatic logic idx_ok(input logic [AW-1:0] a);
    logic [7:0] i;
    i = 8'(a[9:2]);
    idx_ok = (a[AW-1:10] == '0) && ((i >= IDX_CTRL && i <= IDX_NB_W2 && !i[0])
             || i == IDX_EVT || i == IDX_MASK);
  endfunction

  function automatic logic [15:0] lane(input logic [15:0] old, input logic [15:0] nw,
                                       input logic [1:0] st);
    lane = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic mac_eq(input logic [47:0] a, input logic [47:0] b);
    mac_eq = (a == b);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_held, w_held, aw_bad;
  logic [7:0] aw_idx;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  logic [1:0] tmo_en, tmo_en_q;
  logic [31:0] tmo_val;
  logic [EVT_W-1:0] evt, mask, evt_set;
  logic [7:0] bstate [0:1];
  logic [31:0] stamp [0:1];
  logic [31:0] tmr [0:1];
  logic [31:0] next_tmr [0:1];
  logic [47:0] nb_src;
  logic [31:0] frt;
  logic [1:0] frt_frac, tmo_frac;
  logic [1:0] sup_hit, good_hit, en_rise, expire, chg;
  logic [15:0] rd_word, ctl_word, ctl_new;

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  wire wr_go = aw_held && w_held && !s_axi_bvalid_out;
  wire wr_ctrl = wr_go && aw_idx == IDX_CTRL;
  wire wr_tmo_lo = wr_go && aw_idx == IDX_TMO_LO;
  wire wr_tmo_hi = wr_go && aw_idx == IDX_TMO_HI;
  wire wr_evt = wr_go && aw_idx == IDX_EVT;
  wire wr_mask = wr_go && aw_idx == IDX_MASK;
  wire clr_src = wr_ctrl && w_strb[1] && w_data[CTL_CLR_BIT];
  wire [7:0] ar_idx = reg_idx(s_axi_araddr_in);
  wire ar_go = s_axi_arvalid_in && s_axi_arready_out;
  wire [15:0] mask_new = lane(16'(mask), w_data, w_strb);
  wire [15:0] evt_clr = lane(REG_RESET, w_data, w_strb);

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ctl_word = 16'(tmo_en) << CTL_P1_EN_BIT;
  assign ctl_new = lane(ctl_word, w_data, w_strb);
  assign irq_out = |(evt & mask);

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_bad <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= REG_RESET;
      w_strb <= 2'b00;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held <= 1'b1;
        aw_idx <= reg_idx(s_axi_awaddr_in);
        aw_bad <= !idx_ok(s_axi_awaddr_in);
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in[15:0];
        w_strb <= s_axi_wstrb_in[1:0];
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= aw_bad ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path; every word is live, nothing is latched between halves
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = REG_RESET;
    case (ar_idx)
      IDX_CTRL: rd_word = ctl_word; // clear bit always reads zero
      IDX_STATE: rd_word = {bstate[1], bstate[0]};
      IDX_TMO_LO: rd_word = tmo_val[15:0];
      IDX_TMO_HI: rd_word = tmo_val[31:16];
      IDX_P1_TS_LO: rd_word = stamp[0][15:0];
      IDX_P1_TS_HI: rd_word = stamp[0][31:16];
      IDX_P2_TS_LO: rd_word = stamp[1][15:0];
      IDX_P2_TS_HI: rd_word = stamp[1][31:16];
      IDX_NB_W0: rd_word = nb_src[15:0];
      IDX_NB_W1: rd_word = nb_src[31:16];
      IDX_NB_W2: rd_word = nb_src[47:32];
      IDX_EVT: rd_word = 16'(evt);
      IDX_MASK: rd_word = 16'(mask);
      default: rd_word = REG_RESET;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else if (ar_go)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {16'h0000, idx_ok(s_axi_araddr_in) ? rd_word : REG_RESET};
      s_axi_rresp_out <= idx_ok(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // software should only touch tmo_val with both enables clear; a live
  // change is taken at the next load and may fire an early timeout
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      tmo_en <= 2'b00;
      tmo_en_q <= 2'b00;
      tmo_val <= 32'h0000_0000;
      mask <= '0;
      evt <= '0;
    end
    else
    begin
      tmo_en_q <= tmo_en;
      if (wr_ctrl)
        tmo_en <= {ctl_new[CTL_P2_EN_BIT], ctl_new[CTL_P1_EN_BIT]};
      if (wr_tmo_lo)
        tmo_val[15:0] <= lane(tmo_val[15:0], w_data, w_strb);
      if (wr_tmo_hi)
        tmo_val[31:16] <= lane(tmo_val[31:16], w_data, w_strb);
      if (wr_mask)
        mask <= mask_new[EVT_W-1:0];
      // set wins over a write-one-to-clear in the same cycle
      evt <= (evt & ~(wr_evt ? evt_clr[EVT_W-1:0] : '0)) | evt_set;
    end
  end

  // ----------------------------------------------------------------
  // rate generators: quarter-tick accumulators stand in for the
  // 100 and 50 mhz clocks, so counts advance by 2 or 3 and 1 or 2
  // ----------------------------------------------------------------
  wire [3:0] frt_sum = {2'b00, frt_frac} + FRT_STEP_Q;
  wire [3:0] tmo_sum = {2'b00, tmo_frac} + TMO_STEP_Q;
  wire [1:0] frt_inc = frt_sum[3:2];
  wire [1:0] tmo_step = tmo_sum[3:2];

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      frt <= 32'h0000_0000;
      frt_frac <= 2'b00;
      tmo_frac <= 2'b00;
    end
    else
    begin
      frt <= frt + {30'h0, frt_inc};
      frt_frac <= frt_sum[1:0];
      tmo_frac <= tmo_sum[1:0];
    end
  end

  // ----------------------------------------------------------------
  // neighbor-check source capture, port 1
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      nb_src <= 48'h0000_0000_0000;
    else if (neighbor_frame_in.valid)
      nb_src <= neighbor_frame_in.src; // capture beats a clear
    else if (clr_src)
      nb_src <= 48'h0000_0000_0000;
  end

  // ----------------------------------------------------------------
  // per-port beacon tracking
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    assign sup_hit[p] = beacon_in[p].valid
                        && mac_eq(beacon_in[p].src, supervisor_mac_in);
    assign good_hit[p] = sup_hit[p] && !beacon_in[p].crc_err;
    assign en_rise[p] = tmo_en[p] && !tmo_en_q[p];
    // a supervisor beacon without crc error in the expiry cycle wins, so no timeout is flagged then
    assign expire[p] = tmo_en[p] && !en_rise[p] && !good_hit[p]
                       && tmr[p] <= {30'h0, tmo_step};
    assign next_tmr[p] = !tmo_en[p] ? 32'h0000_0000
                       : (en_rise[p] || good_hit[p] || expire[p]) ? tmo_val
                       : tmr[p] - {30'h0, tmo_step};
    assign chg[p] = sup_hit[p] && beacon_in[p].state != bstate[p];
    assign evt_set[EVT_CHG_BIT+p] = chg[p];
    assign evt_set[EVT_TMO_BIT+p] = expire[p];

    always_ff @(posedge sys_clk_in)
    begin
      if (sys_rst_in)
      begin
        tmr[p] <= 32'h0000_0000;
        bstate[p] <= 8'h00;
        stamp[p] <= 32'h0000_0000;
      end
      else
      begin
        tmr[p] <= next_tmr[p];
        if (sup_hit[p])
        begin
          bstate[p] <= beacon_in[p].state;
          stamp[p] <= frt;
        end
      end
    end

    property p_state_take;
      sup_hit[p] |=> bstate[p] == $past(beacon_in[p].state);
    endproperty
    a_state_take: assert property (p_state_take) else $error("state byte not captured");

    property p_foreign_ignored;
      !sup_hit[p] |=> $stable(bstate[p]) && $stable(stamp[p]);
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign beacon used");

    property p_chg_event;
      sup_hit[p] && beacon_in[p].state != bstate[p] |=> evt[EVT_CHG_BIT+p];
    endproperty
    a_chg_event: assert property (p_chg_event) else $error("state change event missing");

    property p_en_load;
      $rose(tmo_en[p]) |=> tmr[p] == $past(tmo_val);
    endproperty
    a_en_load: assert property (p_en_load) else $error("timer not loaded on enable");

    property p_beacon_reload;
      tmo_en[p] && good_hit[p] |-> !evt_set[EVT_TMO_BIT+p] ##1 tmr[p] == $past(tmo_val);
    endproperty
    a_beacon_reload: assert property (p_beacon_reload) else $error("no reload on beacon");

    property p_timeout;
      tmo_en[p] && tmo_en_q[p] && !good_hit[p] && tmr[p] == 32'h0000_0001
      |=> evt[EVT_TMO_BIT+p] && tmr[p] == $past(tmo_val);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not flagged");

    property p_countdown;
      tmo_en[p] && tmo_en_q[p] && !good_hit[p] && tmr[p] > 32'h0000_0002
      |=> tmr[p] < $past(tmr[p]) && $past(tmr[p]) - tmr[p] <= 32'h0000_0002;
    endproperty
    a_countdown: assert property (p_countdown) else $error("timer rate wrong");

    property p_idle;
      !tmo_en[p] |=> tmr[p] == 32'h0000_0000 || tmo_en[p];
    endproperty
    a_idle: assert property (p_idle) else $error("disabled timer moved");

    property p_stamp;
      sup_hit[p] |=> stamp[p] == $past(frt);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp not taken");
  end

  // ----------------------------------------------------------------
  // block-level checks
  // ----------------------------------------------------------------
  property p_frt_rate;
    !$past(sys_rst_in)
    |-> (frt - $past(frt) == 32'h0000_0002) || (frt - $past(frt) == 32'h0000_0003);
  endproperty
  a_frt_rate: assert property (p_frt_rate) else $error("free timer rate wrong");

  property p_frt_avg;
    !$past(sys_rst_in) && !$past(sys_rst_in, 2) |-> frt - $past(frt, 2) == 32'h0000_0005;
  endproperty
  a_frt_avg: assert property (p_frt_avg) else $error("free timer average wrong");

  property p_clear_src;
    clr_src && !neighbor_frame_in.valid |=> nb_src == 48'h0000_0000_0000;
  endproperty
  a_clear_src: assert property (p_clear_src) else $error("source not cleared");

  property p_nb_take;
    neighbor_frame_in.valid |=> nb_src == $past(neighbor_frame_in.src);
  endproperty
  a_nb_take: assert property (p_nb_take) else $error("neighbor source not taken");

  property p_tmo_write;
    wr_tmo_hi && w_strb == 2'b11 |=> tmo_val[31:16] == $past(w_data);
  endproperty
  a_tmo_write: assert property (p_tmo_write) else $error("timeout high not written");

  c_state_change: cover property (sup_hit[0] && chg[0] ##1 irq_out);
  c_timeout: cover property (expire[1]);
  c_beacon_reload: cover property (tmo_en[0] && good_hit[0] && tmr[0] != tmo_val);
  c_clear: cover property (clr_src ##1 nb_src == 48'h0000_0000_0000);

endmodule

// ===== sim/rbm_ring_port_model.sv
// partner model: ring ports delivering beacons and neighbor-check frames
`timescale 1ns/1ps
module rbm_ring_port_model
  import rbm_pkg::*;
(
  input wire logic clk_in, // bench clock
  output rbm_beacon_s beacon_out [0:1], // beacons, index 0 is port 1
  output rbm_frame_s frame_out // port 1 neighbor-check frame
);
  logic [1:0] go = 2'b00;
  logic go_f = 1'b0;
  rbm_beacon_s load [0:1];
  logic [47:0] load_f;
  initial
  begin
    beacon_out[0] = '0;
    beacon_out[1] = '0;
    frame_out = '0;
  end
  // idle payload flips every cycle so a stale field never looks valid
  always @(posedge clk_in)
  begin
    for (int p = 0; p < 2; p++)
      beacon_out[p] <= go[p] ? load[p] : {1'b0, ~beacon_out[p][56:0]};
    frame_out <= go_f ? {1'b1, load_f} : {1'b0, ~frame_out.src};
  end
  // called on a rising edge; the pulse is on the wire one edge later and
  // is taken by the monitor at the edge after that
  task send_beacon(input int p, input logic [47:0] src, input logic [7:0] st,
                   input logic crc);
    load[p] <= {1'b1, crc, src, st};
    go[p] <= 1'b1;
    @(posedge clk_in);
    go[p] <= 1'b0;
    @(posedge clk_in);
    @(posedge clk_in);
  endtask
  task send_frame(input logic [47:0] src);
    load_f <= src;
    go_f <= 1'b1;
    @(posedge clk_in);
    go_f <= 1'b0;
    @(posedge clk_in);
    @(posedge clk_in);
  endtask
endmodule

// ===== sim/ring_beacon_monitor_tb_top.sv
// testbench: register, beacon, timer and neighbor-capture checks
`timescale 1ns/1ps
module ring_beacon_monitor_tb_top
  import rbm_pkg::*;
;
  localparam int TMO_T = 20;
  localparam int EXP_CYC = int'(TMO_T * CLK_HZ / TMO_HZ);
  localparam logic [7:0] RST_IDX [13] = '{IDX_CTRL, IDX_STATE, IDX_TMO_LO, IDX_TMO_HI,
    IDX_P1_TS_LO, IDX_P1_TS_HI, IDX_P2_TS_LO, IDX_P2_TS_HI, IDX_NB_W0, IDX_NB_W1, IDX_NB_W2,
    IDX_EVT, IDX_MASK};
  logic sys_clk_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, t0, t1;
  logic [47:0] mac, f;
  logic [15:0] d;
  logic [7:0] s1, s2;
  rbm_beacon_s bcn [0:1];
  rbm_frame_s nbf;
  int bad_count = 0, n_compared = 0, cycles = 0, seed = 32'hd591, n;
  int exp_st [2] = '{0, 0};
  int exp_evt = 0;
  rbm_ring_beacon_monitor dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .beacon_in(bcn),
    .neighbor_frame_in(nbf), .supervisor_mac_in(mac), .irq_out(irq));
  rbm_ring_port_model pm (.clk_in(sys_clk_in), .beacon_out(bcn), .frame_out(nbf));
  // ----------------------------------------------------------------
  // verdict and helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // handshakes are judged half a cycle early; inputs only move on rising edges
  task automatic wr(input logic [7:0] idx, input logic [15:0] v, output logic [1:0] r);
    logic pa, pw, pb, ta, tw, tb;
    pa = 1;
    pw = 1;
    pb = 1;
    // one edge between transfers so a release is never overwritten in its own step
    @(posedge sys_clk_in);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {16'h0000, v};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pb)
    begin
      @(negedge sys_clk_in);
      ta = pa && awready;
      tw = pw && wready;
      tb = bvalid;
      if (tb)
        r = bresp;
      @(posedge sys_clk_in);
      if (ta) begin awvalid <= 1'b0; pa = 0; end
      if (tw) begin wvalid <= 1'b0; pw = 0; end
      if (tb) begin bready <= 1'b0; pb = 0; end
    end
  endtask
  task automatic rd(input logic [7:0] idx, output logic [15:0] v, output logic [1:0] r);
    logic pa, pr, ta, tr;
    pa = 1;
    pr = 1;
    @(posedge sys_clk_in);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pr)
    begin
      @(negedge sys_clk_in);
      ta = pa && arready;
      tr = rvalid;
      if (tr) begin v = rdata[15:0]; r = rresp; end
      @(posedge sys_clk_in);
      if (ta) begin arvalid <= 1'b0; pa = 0; end
      if (tr) begin rready <= 1'b0; pr = 0; end
    end
  endtask
  task automatic beacon(input int p, input logic [47:0] src, input logic [7:0] st,
                        input logic crc);
    pm.send_beacon(p, src, st, crc);
    if (src === mac)
    begin
      if (st != exp_st[p])
        exp_evt |= 1 << p;
      exp_st[p] = st;
    end
  endtask
  task automatic chk_state();
    rd(IDX_STATE, d, rs);
    chk({16'h0, d}, 32'(exp_st[1] << 8 | exp_st[0]));
    rd(IDX_EVT, d, rs);
    chk({16'h0, d}, 32'(exp_evt));
  endtask
  task automatic stamp(input int p, output logic [31:0] v);
    logic [31:0] prev;
    logic [15:0] lo;
    logic [15:0] hi;
    v = 32'h0;
    prev = 32'h0;
    // accept a value once two whole reads agree, or after the sixth read
    for (int k = 0; k < 6 && (k < 2 || v !== prev); k++)
    begin
      prev = v;
      rd(p ? IDX_P2_TS_LO : IDX_P1_TS_LO, lo, rs);
      rd(p ? IDX_P2_TS_HI : IDX_P1_TS_HI, hi, rs);
      v = {hi, lo};
    end
  endtask
  task automatic irq_is(input logic e);
    @(negedge sys_clk_in);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge sys_clk_in);
  endtask
  task automatic wait_irq();
    for (n = 0; n < 40; n++)
    begin
      @(negedge sys_clk_in);
      if (irq === 1'b1)
        break;
    end
    @(posedge sys_clk_in);
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      bad_count++;
      test_done();
    end
  end
  initial
  begin
    sys_rst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    mac = '0;
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    foreach (RST_IDX[i])
    begin
      rd(RST_IDX[i], d, rs);
      chk({14'h0, rs, d}, {14'h0, RESP_OKAY, REG_RESET});
    end
    rd(8'h10, d, rs);
    chk({14'h0, rs, d}, {14'h0, RESP_SLVERR, 16'h0});
    wr(8'h10, 16'hffff, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    mac <= 48'({$random(seed), $random(seed)});
    @(posedge sys_clk_in);
    for (int b = 0; b < 48; b += 47)
      beacon(0, mac ^ (48'h1 << b), 8'h5a, 1'b0);
    chk_state();
    s1 = 8'($random(seed)) | 8'h01;
    s2 = 8'($random(seed)) | 8'h01;
    beacon(0, mac, s1, 1'b0);
    beacon(1, mac, s2, 1'b1);
    chk_state();
    irq_is(1'b0);
    wr(IDX_MASK, 16'h0003, rs);
    irq_is(1'b1);
    wr(IDX_EVT, 16'h0003, rs);
    exp_evt = 0;
    irq_is(1'b0);
    beacon(0, mac, s1, 1'b0);
    chk_state();
    beacon(0, mac, s1, 1'b0);
    repeat (8) @(posedge sys_clk_in);
    beacon(1, mac, s2, 1'b0);
    stamp(0, t0);
    stamp(1, t1);
    // the two beacons are taken 11 cycles apart: 27.5 ticks of the 100 mhz timer
    n = int'(11 * FRT_HZ / CLK_HZ);
    chk(32'(t1 - t0 == 32'(n) || t1 - t0 == 32'(n + 1)), 32'h1);
    wr(IDX_TMO_HI, 16'h1234, rs);
    rd(IDX_TMO_HI, d, rs);
    chk({16'h0, d}, 32'h1234);
    wr(IDX_TMO_HI, 16'h0000, rs);
    wr(IDX_TMO_LO, 16'(TMO_T), rs);
    rd(IDX_TMO_LO, d, rs);
    chk({16'h0, d}, 32'(TMO_T));
    for (int p = 0; p < 2; p++)
    begin
      wr(IDX_MASK, 16'(1 << (EVT_TMO_BIT + p)), rs);
      wr(IDX_CTRL, 16'(1 << (CTL_P1_EN_BIT + p)), rs);
      wait_irq();
      chk(32'(n >= EXP_CYC - 5 && n <= EXP_CYC + 3), 32'h1);
      wr(IDX_EVT, 16'h000f, rs);
      wait_irq();
      chk(32'(n <= EXP_CYC + 3), 32'h1);
      wr(IDX_EVT, 16'h000f, rs);
      repeat (8)
      begin
        beacon(p, mac, exp_st[p], 1'b0);
        repeat (6) @(posedge sys_clk_in);
      end
      irq_is(1'b0);
      repeat (4)
      begin
        beacon(p, mac, exp_st[p], 1'b1);
        repeat (6) @(posedge sys_clk_in);
      end
      irq_is(1'b1);
      wr(IDX_CTRL, 16'h0000, rs);
      wr(IDX_EVT, 16'h000f, rs);
      repeat (40) @(posedge sys_clk_in);
      irq_is(1'b0);
    end
    f = 48'({$random(seed), $random(seed)});
    pm.send_frame(f);
    rd(IDX_NB_W2, d, rs);
    chk({16'h0, d}, {16'h0, f[47:32]});
    rd(IDX_NB_W0, d, rs);
    chk({16'h0, d}, {16'h0, f[15:0]});
    rd(IDX_NB_W1, d, rs);
    chk({16'h0, d}, {16'h0, f[31:16]});
    wr(IDX_CTRL, 16'(1 << CTL_CLR_BIT), rs);
    rd(IDX_CTRL, d, rs);
    chk({16'h0, d}, 32'h0);
    for (int w = 0; w < 3; w++)
    begin
      rd(IDX_NB_W0 + 8'(2 * w), d, rs);
      chk({16'h0, d}, 32'h0);
    end
    test_done();
  end
endmodule
